// ===== logic/arag_pkg.sv
// shared constants and types for the region access guard
package arag_pkg;
    localparam int NUM_REGIONS = 16;
    localparam int NUM_MASTERS = 4;
    localparam int ID_W        = 10;
    localparam int ADDR_W      = 40;
    localparam int PAGE_LSB    = 8;

    // register byte offsets on the apb port
    localparam logic [11:0] OFS_CTRL    = 12'h000;
    localparam logic [11:0] OFS_ERRS1   = 12'h004;
    localparam logic [11:0] OFS_ERRS2   = 12'h008;
    localparam logic [11:0] OFS_POISON  = 12'h00C;
    localparam logic [11:0] OFS_ISR     = 12'h010;
    localparam logic [11:0] OFS_IMR     = 12'h014;
    localparam logic [11:0] OFS_IER     = 12'h018;
    localparam logic [11:0] OFS_IDS     = 12'h01C;
    localparam logic [11:0] OFS_LOCK    = 12'h020;
    localparam logic [11:0] OFS_BYPASS  = 12'h024;
    localparam logic [11:0] OFS_REGIONS = 12'h028;
    localparam logic [3:0]  REGION_PAGE = 4'h1;
    localparam logic [1:0]  RSEL_START   = 2'h0;
    localparam logic [1:0]  RSEL_END     = 2'h1;
    localparam logic [1:0]  RSEL_MASTERS = 2'h2;
    localparam logic [1:0]  RSEL_CONFIG  = 2'h3;

    // control fields
    localparam int CTRL_DEFRD     = 0;
    localparam int CTRL_DEFWR     = 1;
    localparam int CTRL_PSNADDREN = 2;
    localparam int CTRL_PSNATTREN = 3;
    localparam int CTRL_ARSP_LSB  = 5;
    localparam logic [31:0] CTRL_WMASK = 32'h0000006F;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;

    // region config fields
    localparam int RCFG_ENABLE = 0;
    localparam int RCFG_RD     = 1;
    localparam int RCFG_WR     = 2;
    localparam logic [31:0] RCFG_WMASK = 32'h00000007;

    // interrupt status / enable bits
    localparam int IRQ_READ_VIOLATION_FLAG = 0;
    localparam int IRQ_WRITE_VIOLATION_FLAG = 1;

    localparam logic [31:0] REG_RESET = 32'h00000000;

    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_EXOKAY = 2'h1;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // master identification: bit order of every master mask
    localparam int M_RT0  = 0;
    localparam int M_RT1  = 1;
    localparam int M_PMU  = 2;
    localparam int M_APP  = 3;
    localparam logic [9:0] realtime_core0_master_id      = 10'h000;
    localparam logic [9:0] realtime_core0_master_mask    = 10'h3F0;
    localparam logic [9:0] realtime_core1_master_id      = 10'h010;
    localparam logic [9:0] realtime_core1_master_mask    = 10'h3F0;
    localparam logic [9:0] platform_management_master_id   = 10'h040;
    localparam logic [9:0] platform_management_master_mask = 10'h3FF;
    localparam logic [9:0] application_cores_master_id   = 10'h080;
    localparam logic [9:0] application_cores_master_mask = 10'h3FF;

    typedef enum logic [2:0] {
        G_IDLE = 3'b001,
        G_TGT  = 3'b010,
        G_RSP  = 3'b100
    } arag_gstate_t;

    typedef enum logic [2:0] {
        M_IDLE = 3'b001,
        M_REQ  = 3'b010,
        M_WAIT = 3'b100
    } arag_mstate_t;

    function automatic logic [NUM_MASTERS-1:0] arag_master_bits(input logic [9:0] id);
        logic [NUM_MASTERS-1:0] b;
        b        = '0;
        b[M_RT0] = (id & realtime_core0_master_mask) == realtime_core0_master_id;
        b[M_RT1] = (id & realtime_core1_master_mask) == realtime_core1_master_id;
        b[M_PMU] = (id & platform_management_master_mask) == platform_management_master_id;
        b[M_APP] = (id & application_cores_master_mask) == application_cores_master_id;
        return b;
    endfunction
endpackage

// ===== logic/arag_link_if.sv
// request and response link between the bus masters and the guard
`timescale 1ns/1ns
interface arag_link_if;
    logic        req_valid;
    logic        req_ready;
    logic [9:0]  req_id;
    logic [39:0] req_addr;
    logic        req_write;
    logic [31:0] req_wdata;
    logic        rsp_valid;
    logic [1:0]  rsp_code;
    logic [31:0] rsp_rdata;

    modport device (
        input  req_valid, req_id, req_addr, req_write, req_wdata,
        output req_ready, rsp_valid, rsp_code, rsp_rdata
    );
    modport master (
        output req_valid, req_id, req_addr, req_write, req_wdata,
        input  req_ready, rsp_valid, rsp_code, rsp_rdata
    );
endinterface

// ===== logic/arag_region_match.sv
// one protected region: range compare and permission check
`timescale 1ns/1ns
module arag_region_match (
    input  wire logic [31:0] start_page,  // start, upper bits of byte address
    input  wire logic [31:0] end_page,    // inclusive end, same format
    input  wire logic [31:0] masters,     // one bit per master
    input  wire logic [31:0] config_word, // enable, read, write
    input  wire logic [39:0] addr,        // transaction byte address
    input  wire logic [3:0]  mbits,       // decoded master of transaction
    output logic             hit,         // address inside enabled region
    output logic             rd_ok,       // read allowed here
    output logic             wr_ok        // write allowed here
);
    logic [31:0] page;
    logic        who_ok;

    assign page   = addr[39:arag_pkg::PAGE_LSB];
    assign hit    = config_word[arag_pkg::RCFG_ENABLE] && page >= start_page && page <= end_page;
    assign who_ok = |(masters[arag_pkg::NUM_MASTERS-1:0] & mbits);
    assign rd_ok  = who_ok && config_word[arag_pkg::RCFG_RD];
    assign wr_ok  = who_ok && config_word[arag_pkg::RCFG_WR];
endmodule

// ===== logic/arag_guard_unit.sv
// protection unit: apb registers, region checks, target forwarding
`timescale 1ns/1ns
// What this block does
// - region miss uses default read/write permissions
// - control holds defaults, poison enables, response
// - lock refuses config writes except bypass masters
// - separate read/write violations, each enable
// - status sticky until cleared by software
// - start is upper bits of address
// - region covers start through programmed end
// - mask bit per master grants region access
// - sixteen readable region register sets
// - masters identified by masked id compare
// - application and realtime1 ids recognised too
// - software configures control before lock, regions
// - enable/disable writes touch only masked bits
// - status read has no side effect
module arag_guard_unit (
    input  wire logic        pclk,          // clock
    input  wire logic        presetn,       // async reset, active low
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb enable
    input  wire logic        pwrite,        // apb direction
    input  wire logic [11:0] paddr,         // apb byte address
    input  wire logic [31:0] pwdata,        // apb write data
    input  wire logic [9:0]  cfg_master_id, // id of the master doing the apb transfer
    output logic      [31:0] prdata,        // apb read data
    output logic             pready,        // apb ready
    output logic             pslverr,       // apb error
    output logic             irq,           // level interrupt
    arag_link_if.device      link,          // masters side
    output logic             tgt_valid,     // request to protected target
    input  wire logic        tgt_ready,     // target done
    output logic             tgt_write,     // target direction
    output logic      [39:0] tgt_addr,      // target address
    output logic      [31:0] tgt_wdata,     // target write data
    input  wire logic [31:0] tgt_rdata      // target read data
);
    localparam int NR = arag_pkg::NUM_REGIONS;

    logic [31:0] ctrl_reg, errs1_reg, errs2_reg, poison_reg;
    logic [31:0] isr_reg, imr_reg, lock_reg, bypass_reg;
    logic [31:0] start_reg [NR];
    logic [31:0] end_reg   [NR];
    logic [31:0] mast_reg  [NR];
    logic [31:0] cfg_reg   [NR];
    logic        ack_reg;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;
    arag_pkg::arag_gstate_t state_reg;
    logic        tgt_valid_reg, tgt_write_reg;
    logic [39:0] tgt_addr_reg;
    logic [31:0] tgt_wdata_reg;
    logic        rsp_valid_reg;
    logic [1:0]  rsp_code_reg;
    logic [31:0] rsp_rdata_reg;

    logic [NR-1:0] hit, rd_ok, wr_ok;
    logic [3:0]    req_mbits;
    logic          sel_rd, sel_wr, allowed, take;
    logic          rd_vio, wr_vio;
    logic          access, wr_en, cfg_ok, in_region, mapped, locked_ofs;
    logic [3:0]    ridx;
    logic [1:0]    rsel;
    logic [31:0]   rd_data_next;
    logic          err_next;

    // ---------------- transaction check ----------------
    assign req_mbits = arag_pkg::arag_master_bits(link.req_id);

    for (genvar g = 0; g < NR; g++) begin : g_region
        arag_region_match u_match (
            .start_page  (start_reg[g]),
            .end_page    (end_reg[g]),
            .masters     (mast_reg[g]),
            .config_word (cfg_reg[g]),
            .addr        (link.req_addr),
            .mbits       (req_mbits),
            .hit         (hit[g]),
            .rd_ok       (rd_ok[g]),
            .wr_ok       (wr_ok[g])
        );
    end

    // lowest-numbered matching region wins; overlaps resolve predictably
    always_comb begin
        sel_rd = ctrl_reg[arag_pkg::CTRL_DEFRD];
        sel_wr = ctrl_reg[arag_pkg::CTRL_DEFWR];
        for (int i = NR - 1; i >= 0; i--) begin
            if (hit[i]) begin
                sel_rd = rd_ok[i];
                sel_wr = wr_ok[i];
            end
        end
        allowed = link.req_write ? sel_wr : sel_rd;
    end

    assign link.req_ready = (state_reg == arag_pkg::G_IDLE);
    assign take           = link.req_valid && link.req_ready;
    assign rd_vio         = take && !allowed && !link.req_write;
    assign wr_vio         = take && !allowed && link.req_write;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= arag_pkg::G_IDLE;
        end else begin
            case (state_reg)
                arag_pkg::G_IDLE: begin
                    if (take) begin
                        state_reg <= allowed ? arag_pkg::G_TGT : arag_pkg::G_RSP;
                    end
                end
                arag_pkg::G_TGT: begin
                    if (tgt_ready) begin
                        state_reg <= arag_pkg::G_RSP;
                    end
                end
                arag_pkg::G_RSP: state_reg <= arag_pkg::G_IDLE;
                default:         state_reg <= arag_pkg::G_IDLE;
            endcase
        end
    end

    // target side: a denied request never raises tgt_valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tgt_valid_reg <= 1'b0;
            tgt_write_reg <= 1'b0;
            tgt_addr_reg  <= '0;
            tgt_wdata_reg <= '0;
        end else if (take) begin
            tgt_valid_reg <= allowed;
            tgt_write_reg <= link.req_write;
            tgt_addr_reg  <= link.req_addr;
            tgt_wdata_reg <= link.req_wdata;
        end else if (state_reg == arag_pkg::G_TGT && tgt_ready) begin
            tgt_valid_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_valid_reg <= 1'b0;
            rsp_code_reg  <= arag_pkg::RESP_OKAY;
            rsp_rdata_reg <= '0;
        end else if (take && !allowed) begin
            rsp_valid_reg <= 1'b1;
            rsp_code_reg  <= ctrl_reg[arag_pkg::CTRL_ARSP_LSB +: 2];
            rsp_rdata_reg <= '0;
        end else if (state_reg == arag_pkg::G_TGT && tgt_ready) begin
            rsp_valid_reg <= 1'b1;
            rsp_code_reg  <= arag_pkg::RESP_OKAY;
            rsp_rdata_reg <= tgt_write_reg ? 32'h00000000 : tgt_rdata;
        end else begin
            rsp_valid_reg <= 1'b0;
        end
    end

    assign link.rsp_valid = rsp_valid_reg;
    assign link.rsp_code  = rsp_code_reg;
    assign link.rsp_rdata = rsp_rdata_reg;
    assign tgt_valid      = tgt_valid_reg;
    assign tgt_write      = tgt_write_reg;
    assign tgt_addr       = tgt_addr_reg;
    assign tgt_wdata      = tgt_wdata_reg;

    // ---------------- apb slave ----------------
    // one wait state so read data leaves from a flop
    assign access = psel && penable;
    assign wr_en  = access && pwrite && ack_reg;
    assign ridx   = paddr[7:4];
    assign rsel   = paddr[3:2];
    assign in_region = (paddr[11:8] == arag_pkg::REGION_PAGE) && (paddr[1:0] == 2'h0);
    assign cfg_ok = !lock_reg[0] || |(bypass_reg[arag_pkg::NUM_MASTERS-1:0]
                    & arag_pkg::arag_master_bits(cfg_master_id));
    // interrupt registers stay writable under lock so the handler can run
    assign locked_ofs = in_region || paddr == arag_pkg::OFS_CTRL || paddr == arag_pkg::OFS_POISON
                        || paddr == arag_pkg::OFS_LOCK || paddr == arag_pkg::OFS_BYPASS;

    always_comb begin
        rd_data_next = 32'h00000000;
        mapped       = 1'b1;
        if (in_region) begin
            if (rsel == arag_pkg::RSEL_START) begin
                rd_data_next = start_reg[ridx];
            end else if (rsel == arag_pkg::RSEL_END) begin
                rd_data_next = end_reg[ridx];
            end else if (rsel == arag_pkg::RSEL_MASTERS) begin
                rd_data_next = mast_reg[ridx];
            end else begin
                rd_data_next = cfg_reg[ridx];
            end
        end else if (paddr == arag_pkg::OFS_CTRL) begin
            rd_data_next = ctrl_reg;
        end else if (paddr == arag_pkg::OFS_ERRS1) begin
            rd_data_next = errs1_reg;
        end else if (paddr == arag_pkg::OFS_ERRS2) begin
            rd_data_next = errs2_reg;
        end else if (paddr == arag_pkg::OFS_POISON) begin
            rd_data_next = poison_reg;
        end else if (paddr == arag_pkg::OFS_ISR) begin
            rd_data_next = isr_reg;
        end else if (paddr == arag_pkg::OFS_IMR) begin
            rd_data_next = imr_reg;
        end else if (paddr == arag_pkg::OFS_IER || paddr == arag_pkg::OFS_IDS) begin
            rd_data_next = 32'h00000000;
        end else if (paddr == arag_pkg::OFS_LOCK) begin
            rd_data_next = lock_reg;
        end else if (paddr == arag_pkg::OFS_BYPASS) begin
            rd_data_next = bypass_reg;
        end else if (paddr == arag_pkg::OFS_REGIONS) begin
            rd_data_next = 32'(NR);
        end else begin
            mapped = 1'b0;
        end
        err_next = !mapped || (pwrite && locked_ofs && !cfg_ok);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_reg     <= 1'b0;
            prdata_reg  <= arag_pkg::REG_RESET;
            pslverr_reg <= 1'b0;
        end else begin
            ack_reg <= access && !ack_reg;
            if (access && !ack_reg) begin
                prdata_reg  <= pwrite ? 32'h00000000 : rd_data_next;
                pslverr_reg <= err_next;
            end
        end
    end

    assign pready  = ack_reg;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;

    // configuration registers, all behind the lock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg   <= arag_pkg::CTRL_RESET;
            poison_reg <= arag_pkg::REG_RESET;
            lock_reg   <= arag_pkg::REG_RESET;
            bypass_reg <= arag_pkg::REG_RESET;
        end else if (wr_en && cfg_ok) begin
            if (paddr == arag_pkg::OFS_CTRL) begin
                ctrl_reg <= pwdata & arag_pkg::CTRL_WMASK;
            end else if (paddr == arag_pkg::OFS_POISON) begin
                poison_reg <= pwdata;
            end else if (paddr == arag_pkg::OFS_LOCK) begin
                lock_reg <= {31'h00000000, pwdata[0]};
            end else if (paddr == arag_pkg::OFS_BYPASS) begin
                bypass_reg <= {28'h0000000, pwdata[arag_pkg::NUM_MASTERS-1:0]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NR; i++) begin
                start_reg[i] <= arag_pkg::REG_RESET;
                end_reg[i]   <= arag_pkg::REG_RESET;
                mast_reg[i]  <= arag_pkg::REG_RESET;
                cfg_reg[i]   <= arag_pkg::REG_RESET;
            end
        end else if (wr_en && cfg_ok && in_region) begin
            case (rsel)
                arag_pkg::RSEL_START:   start_reg[ridx] <= pwdata;
                arag_pkg::RSEL_END:     end_reg[ridx]   <= pwdata;
                arag_pkg::RSEL_MASTERS: mast_reg[ridx]  <= {28'h0000000, pwdata[arag_pkg::NUM_MASTERS-1:0]};
                default:                cfg_reg[ridx]   <= pwdata & arag_pkg::RCFG_WMASK;
            endcase
        end
    end

    // ---------------- violations and interrupt ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imr_reg <= arag_pkg::REG_RESET;
        end else if (wr_en && paddr == arag_pkg::OFS_IER) begin
            imr_reg <= imr_reg | (pwdata & 32'h00000003);
        end else if (wr_en && paddr == arag_pkg::OFS_IDS) begin
            imr_reg <= imr_reg & ~pwdata;
        end
    end

    // a violation in the clearing cycle survives the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            isr_reg <= arag_pkg::REG_RESET;
        end else begin
            isr_reg <= (isr_reg & ~((wr_en && paddr == arag_pkg::OFS_ISR) ? pwdata : 32'h00000000))
                       | {30'h00000000, wr_vio, rd_vio};
        end
    end

    // last violation: page address, then direction and id
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            errs1_reg <= arag_pkg::REG_RESET;
            errs2_reg <= arag_pkg::REG_RESET;
        end else if (rd_vio || wr_vio) begin
            errs1_reg <= link.req_addr[39:arag_pkg::PAGE_LSB];
            errs2_reg <= {link.req_write, 21'h000000, link.req_id};
        end
    end

    assign irq = |(isr_reg & imr_reg);
endmodule

// ===== logic/arag_bus_master.sv
// master end: turns user commands into guarded link transactions
`timescale 1ns/1ns
module arag_bus_master (
    input  wire logic        pclk,       // clock
    input  wire logic        presetn,    // async reset, active low
    input  wire logic        cmd_valid,  // user command present
    output logic             cmd_ready,  // command taken this cycle
    input  wire logic [9:0]  cmd_id,     // master identifier
    input  wire logic [39:0] cmd_addr,   // byte address
    input  wire logic        cmd_write,  // 1 write, 0 read
    input  wire logic [31:0] cmd_wdata,  // write data
    output logic             done,       // one-cycle completion pulse
    output logic      [1:0]  done_resp,  // axi response code
    output logic      [31:0] done_rdata, // read data
    arag_link_if.master      link        // to the guard
);
    arag_pkg::arag_mstate_t state_reg;
    logic        req_valid_reg, req_write_reg;
    logic [9:0]  req_id_reg;
    logic [39:0] req_addr_reg;
    logic [31:0] req_wdata_reg;
    logic        done_reg;
    logic [1:0]  resp_reg;
    logic [31:0] rdata_reg;

    assign cmd_ready = (state_reg == arag_pkg::M_IDLE);

    // request held stable until the guard takes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg     <= arag_pkg::M_IDLE;
            req_valid_reg <= 1'b0;
            req_write_reg <= 1'b0;
            req_id_reg    <= '0;
            req_addr_reg  <= '0;
            req_wdata_reg <= '0;
        end else begin
            case (state_reg)
                arag_pkg::M_IDLE: begin
                    if (cmd_valid) begin
                        state_reg     <= arag_pkg::M_REQ;
                        req_valid_reg <= 1'b1;
                        req_write_reg <= cmd_write;
                        req_id_reg    <= cmd_id;
                        req_addr_reg  <= cmd_addr;
                        req_wdata_reg <= cmd_wdata;
                    end
                end
                arag_pkg::M_REQ: begin
                    if (link.req_ready) begin
                        state_reg     <= arag_pkg::M_WAIT;
                        req_valid_reg <= 1'b0;
                    end
                end
                arag_pkg::M_WAIT: begin
                    if (link.rsp_valid) begin
                        state_reg <= arag_pkg::M_IDLE;
                    end
                end
                default: state_reg <= arag_pkg::M_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_reg  <= 1'b0;
            resp_reg  <= arag_pkg::RESP_OKAY;
            rdata_reg <= '0;
        end else begin
            done_reg <= (state_reg == arag_pkg::M_WAIT) && link.rsp_valid;
            if (state_reg == arag_pkg::M_WAIT && link.rsp_valid) begin
                resp_reg  <= link.rsp_code;
                rdata_reg <= link.rsp_rdata;
            end
        end
    end

    assign link.req_valid = req_valid_reg;
    assign link.req_write = req_write_reg;
    assign link.req_id    = req_id_reg;
    assign link.req_addr  = req_addr_reg;
    assign link.req_wdata = req_wdata_reg;
    assign done       = done_reg;
    assign done_resp  = resp_reg;
    assign done_rdata = rdata_reg;
endmodule

// ===== test/arag_link_checker.sv
// protocol checks on the link between bus master end and guard
`timescale 1ns/1ns
module arag_link_checker (
    input wire logic        pclk,      // clock
    input wire logic        presetn,   // reset
    input wire logic        req_valid, // request
    input wire logic        req_ready, // guard idle
    input wire logic [9:0]  req_id,    // id
    input wire logic [39:0] req_addr,  // address
    input wire logic        req_write, // direction
    input wire logic [31:0] req_wdata, // data
    input wire logic        rsp_valid, // answer
    input wire logic [1:0]  rsp_code,  // code
    input wire logic [31:0] rsp_rdata  // read data
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_hold; req_valid && !req_ready |=> req_valid && $stable({req_id, req_addr, req_write, req_wdata}); endproperty
    a_hold: assert property (p_hold) else $error("request changed before take");
    property p_take; req_valid && req_ready |=> !req_ready; endproperty
    a_take: assert property (p_take) else $error("second request accepted while busy");
    property p_pulse; rsp_valid |=> !rsp_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
    property p_idle; rsp_valid |=> req_ready; endproperty
    a_idle: assert property (p_idle) else $error("guard not idle after answer");
    property p_busy; rsp_valid |-> !req_ready && !req_valid; endproperty
    a_busy: assert property (p_busy) else $error("answer while idle or new request");
    property p_bound; req_valid && req_ready |-> ##[1:64] rsp_valid; endproperty
    a_bound: assert property (p_bound) else $error("no answer to request");
    property p_keep; !rsp_valid ##1 !rsp_valid |-> $stable(rsp_code) && $stable(rsp_rdata); endproperty
    a_keep: assert property (p_keep) else $error("answer changed between answers");
    property p_drop; $fell(req_ready) |-> $past(req_valid); endproperty
    a_drop: assert property (p_drop) else $error("guard busy without request");
endmodule

// ===== test/axi_region_access_guard_tb_top.sv
// self-checking bench: bus master end and guard joined by the link
`timescale 1ns/1ns
`define CHK(x, y) begin checked++; if ((x) !== (y)) begin error_cnt++; $display("CHECK FAILED %0t mismatch", $time); end end
module axi_region_access_guard_tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, tgt_rdata = 32'h0, cmd_wdata = 32'h0, done_rdata, prd, rs = 32'h1B6DE2F4;
    logic [31:0] sr = 32'h1B6DE2F4;
    logic [9:0]  cfg_master_id = 10'h000, cmd_id = 10'h000;
    logic [39:0] tgt_addr, cmd_addr = 40'h0, ta;
    logic        pready, pslverr, irq, tgt_valid, tgt_ready = 1'b0, cmd_valid = 1'b0, cmd_ready, cmd_write = 1'b0;
    logic        done, pe;
    logic [1:0]  done_resp, arsp;
    int          error_cnt = 0, checked = 0, tn = 0, cyc = 0;
    arag_link_if lk ();
    arag_guard_unit arag_guard_unit_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .cfg_master_id,
        .prdata, .pready, .pslverr, .irq, .link(lk), .tgt_valid, .tgt_ready, .tgt_write(), .tgt_addr, .tgt_wdata(),
        .tgt_rdata);
    arag_bus_master arag_bus_master_i (.pclk, .presetn, .cmd_valid, .cmd_ready, .cmd_id, .cmd_addr, .cmd_write,
        .cmd_wdata, .done, .done_resp, .done_rdata, .link(lk));
    arag_link_checker arag_link_checker_i (.pclk, .presetn, .req_valid(lk.req_valid), .req_ready(lk.req_ready),
        .req_id(lk.req_id), .req_addr(lk.req_addr), .req_write(lk.req_write), .req_wdata(lk.req_wdata),
        .rsp_valid(lk.rsp_valid), .rsp_code(lk.rsp_code), .rsp_rdata(lk.rsp_rdata));
    always #25 pclk = ~pclk;
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [1:0] er(input logic ok);
        return ok ? arag_pkg::RESP_OKAY : arsp;
    endfunction
    task automatic final_report;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // target stalls at random; counts what actually reached it
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        sr <= nx(sr);
        tgt_ready <= tgt_valid && !tgt_ready && sr[0];
        if (tgt_valid && tgt_ready) begin
            tn <= tn + 1;
            ta <= tgt_addr;
        end
        if (cyc == 20000) begin
            error_cnt++;
            final_report;
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [9:0] id);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; cfg_master_id <= id;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        prd = prdata; pe = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic cmd(input logic [9:0] id, input logic [39:0] ad, input logic w, input logic ok);
        int n;
        n = tn;
        rs = nx(rs);
        @(posedge pclk);
        cmd_valid <= 1'b1; cmd_id <= id; cmd_addr <= ad; cmd_write <= w; cmd_wdata <= rs; tgt_rdata <= rs;
        do @(posedge pclk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        do @(posedge pclk); while (done !== 1'b1);
        `CHK(done_resp, er(ok))
        `CHK(tn - n, int'(ok))
        if (ok) `CHK(done_rdata, w ? 32'h0 : rs)
        if (ok) `CHK(ta, ad)
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, arag_pkg::OFS_REGIONS, 0, 0); `CHK(prd, 32'h10)
        apb(0, 12'hFF0, 0, 0); `CHK(pe, 1'b1)
        apb(1, arag_pkg::OFS_IER, 3, 0);
        apb(1, arag_pkg::OFS_IDS, 1, 0);
        apb(0, arag_pkg::OFS_IMR, 0, 0); `CHK(prd, 32'h2)
        for (int c = 0; c < 4; c++) begin
            arsp = c[1:0];
            apb(1, arag_pkg::OFS_CTRL, c << 5, 0);
            cmd(10'h080, {8'h00, rs}, 1'b0, 1'b0);
            cmd(10'h040, {8'h00, rs}, 1'b1, 1'b0);
        end
        `CHK(irq, 1'b1)
        apb(0, arag_pkg::OFS_ISR, 0, 0); `CHK(prd, 32'h3)
        apb(0, arag_pkg::OFS_ISR, 0, 0); `CHK(prd, 32'h3)
        apb(1, arag_pkg::OFS_ISR, 3, 0);
        apb(0, arag_pkg::OFS_ISR, 0, 0); `CHK(prd, 32'h0)
        `CHK(irq, 1'b0)
        arsp = arag_pkg::RESP_DECERR;
        apb(1, arag_pkg::OFS_CTRL, 32'h63, 0);
        apb(1, 12'h100, 32'h00123450, 0);
        apb(1, 12'h104, 32'h00123453, 0);
        apb(1, 12'h108, 32'h1, 0);
        apb(1, 12'h10C, 32'h7, 0);
        apb(0, 12'h104, 0, 0); `CHK(prd, 32'h00123453)
        cmd({6'h00, rs[3:0]}, {32'h00123450, rs[7:0]}, rs[4], 1'b1);
        cmd(10'h080, 40'h00123453FF, 1'b0, 1'b0);
        cmd({6'h01, rs[3:0]}, 40'h0012345000, 1'b1, 1'b0);
        cmd(10'h080, 40'h0012345400, 1'b1, 1'b1);
        cmd(10'h040, 40'h0012344FFF, 1'b0, 1'b1);
        apb(1, arag_pkg::OFS_BYPASS, 32'h4, 0);
        apb(1, arag_pkg::OFS_LOCK, 32'h1, 0);
        apb(1, arag_pkg::OFS_CTRL, 32'h0, 10'h080); `CHK(pe, 1'b1)
        apb(0, arag_pkg::OFS_CTRL, 0, 10'h080); `CHK(prd, 32'h63)
        apb(1, arag_pkg::OFS_CTRL, 32'h63, 10'h040); `CHK(pe, 1'b0)
        final_report;
    end
endmodule
